// *** rtl/apv_pkg.sv ***
package apv_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_CONTROL = 4'hc;
    localparam int ADDR_W = 4;

    // ==========================================================
    // Device status fields
    localparam int ST_MISSING = 0;
    localparam int ST_EARLY = 1;
    localparam int ST_REF_SEEN = 2;
    localparam int ST_EARLY_PEND = 3;
    localparam int ST_CARRY = 4;
    localparam int ST_COUNT_LSB = 16;

    // ==========================================================
    // Interrupt status / mask fields
    localparam int IRQ_W = 3;
    localparam int IRQ_MISSING = 0;
    localparam int IRQ_EARLY = 1;
    localparam int IRQ_STROBE = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // ==========================================================
    // Control fields
    localparam int CTL_ENABLE = 0;
    localparam logic CTL_ENABLE_RST = 1'b1;

    // ==========================================================
    // Counter and bus constants
    localparam int CHANGE_CNT_W = 14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/apv_azimuth_pulse_validator.sv ***
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module apv_azimuth_pulse_validator #(
    parameter int CNT_W = apv_pkg::CHANGE_CNT_W
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic azimuth_change_pulse, // Change pulse pin
    input wire logic azimuth_north_pulse, // Reference pulse pin
    output logic azimuth_strobe, // One-cycle strobe on good revolution
    output logic [CNT_W-1:0] azimuth_count, // Current change count
    output logic irq, // Level interrupt
    input wire logic [apv_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [apv_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read data ready
);

    generate
        if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
            $error("CNT_W must lie in 2..16");
        end
    endgenerate

    // ==========================================================
    // Pin synchronisers and edge detectors
    logic change_pulse_lead_edge;
    logic north_pulse_trail_edge;

    // Change pulse counts on its leading edge
    apv_edge_sync #(
        .FALLING(1'b0)
    ) u_change_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(azimuth_change_pulse),
        .edge_pulse(change_pulse_lead_edge)
    );

    // Reference event is the trailing edge
    apv_edge_sync #(
        .FALLING(1'b1)
    ) u_north_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin(azimuth_north_pulse),
        .edge_pulse(north_pulse_trail_edge)
    );

    // ==========================================================
    // Bus slave
    logic [apv_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic aw_held, next_aw_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_held, next_w_held;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write;
    logic status_read;
    logic [31:0] status_word;
    logic [apv_pkg::IRQ_W-1:0] irq_status, irq_mask;
    logic ctl_enable;
    logic missing_err, early_err, ref_seen, early_pend, count_wrap_carry;
    logic [CNT_W-1:0] change_cnt;

    always_comb begin
        status_word = '0;
        status_word[apv_pkg::ST_MISSING] = missing_err;
        status_word[apv_pkg::ST_EARLY] = early_err;
        status_word[apv_pkg::ST_REF_SEEN] = ref_seen;
        status_word[apv_pkg::ST_EARLY_PEND] = early_pend;
        status_word[apv_pkg::ST_CARRY] = count_wrap_carry;
        status_word[apv_pkg::ST_COUNT_LSB +: CNT_W] = change_cnt;
    end

    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_held = aw_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_held = w_held;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        do_write = 1'b0;
        status_read = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_held = 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            case (aw_addr)
                apv_pkg::ADDR_STATUS, apv_pkg::ADDR_IRQ_STATUS,
                apv_pkg::ADDR_IRQ_MASK, apv_pkg::ADDR_CONTROL: next_bresp = apv_pkg::RESP_OKAY;
                default: next_bresp = apv_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = apv_pkg::RESP_OKAY;
            next_rdata = '0;
            case (s_axi_araddr)
                apv_pkg::ADDR_STATUS: begin
                    next_rdata = status_word;
                    status_read = 1'b1;
                end
                apv_pkg::ADDR_IRQ_STATUS: next_rdata[apv_pkg::IRQ_W-1:0] = irq_status;
                apv_pkg::ADDR_IRQ_MASK: next_rdata[apv_pkg::IRQ_W-1:0] = irq_mask;
                apv_pkg::ADDR_CONTROL: next_rdata[apv_pkg::CTL_ENABLE] = ctl_enable;
                default: next_rresp = apv_pkg::RESP_SLVERR;
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_addr <= '0;
            aw_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= apv_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= apv_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            aw_addr <= next_aw_addr;
            aw_held <= next_aw_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_held <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Validator core, interrupts and control
    logic [CNT_W-1:0] next_change_cnt;
    logic next_carry, next_ref_seen, next_early_pend, next_missing, next_early;
    logic next_strobe, next_irq, next_enable;
    logic [apv_pkg::IRQ_W-1:0] next_irq_status, next_irq_mask, irq_events, w1c;
    logic lead, trail;

    always_comb begin
        lead = change_pulse_lead_edge && ctl_enable;
        trail = north_pulse_trail_edge && ctl_enable;
        next_change_cnt = change_cnt;
        next_carry = count_wrap_carry;
        next_ref_seen = ref_seen;
        next_early_pend = early_pend;
        next_missing = missing_err;
        next_early = early_err;
        next_strobe = 1'b0;
        next_enable = ctl_enable;
        next_irq_mask = irq_mask;
        irq_events = '0;
        w1c = '0;
        // Status read clears first; events below win over it
        if (status_read) begin
            next_missing = 1'b0;
            next_early = 1'b0;
            next_early_pend = 1'b0;
        end
        if (trail && count_wrap_carry) begin
            next_ref_seen = 1'b1;
        end
        if (trail && !count_wrap_carry) begin
            next_early_pend = 1'b1;
        end
        if (lead) begin
            if (count_wrap_carry) begin
                next_carry = 1'b0;
                next_change_cnt = '0;
                if (ref_seen) begin
                    next_strobe = 1'b1;
                    next_ref_seen = 1'b0;
                    irq_events[apv_pkg::IRQ_STROBE] = 1'b1;
                end else begin
                    next_missing = 1'b1;
                    irq_events[apv_pkg::IRQ_MISSING] = 1'b1;
                end
            end else if (early_pend) begin
                next_early_pend = trail;
                next_early = 1'b1;
                next_change_cnt = '0;
                irq_events[apv_pkg::IRQ_EARLY] = 1'b1;
            end else begin
                next_change_cnt = change_cnt + 1'b1;
                if (&change_cnt) begin
                    next_carry = 1'b1;
                end
            end
        end
        if (do_write) begin
            case (aw_addr)
                apv_pkg::ADDR_IRQ_STATUS: if (w_strb[0]) w1c = w_data[apv_pkg::IRQ_W-1:0];
                apv_pkg::ADDR_IRQ_MASK: if (w_strb[0]) next_irq_mask = w_data[apv_pkg::IRQ_W-1:0];
                apv_pkg::ADDR_CONTROL: if (w_strb[0]) next_enable = w_data[apv_pkg::CTL_ENABLE];
                default: ;
            endcase
        end
        next_irq_status = (irq_status & ~w1c) | irq_events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            change_cnt <= '0;
            count_wrap_carry <= 1'b0;
            ref_seen <= 1'b0;
            early_pend <= 1'b0;
            missing_err <= 1'b0;
            early_err <= 1'b0;
            azimuth_strobe <= 1'b0;
            irq <= 1'b0;
            irq_status <= '0;
            irq_mask <= apv_pkg::IRQ_MASK_RST;
            ctl_enable <= apv_pkg::CTL_ENABLE_RST;
        end else begin
            change_cnt <= next_change_cnt;
            count_wrap_carry <= next_carry;
            ref_seen <= next_ref_seen;
            early_pend <= next_early_pend;
            missing_err <= next_missing;
            early_err <= next_early;
            azimuth_strobe <= next_strobe;
            irq <= next_irq;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            ctl_enable <= next_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            azimuth_count <= '0;
        end else begin
            azimuth_count <= next_change_cnt;
        end
    end

endmodule // apv_azimuth_pulse_validator

// ==========================================================
// Two-flop pin synchroniser with one-cycle edge pulse
module apv_edge_sync #(
    parameter bit FALLING = 1'b0
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic pin, // Asynchronous pin
    output logic edge_pulse // One-cycle pulse on the chosen edge
);

    logic sync_1, sync_2, sync_prev;
    logic next_sync_1, next_sync_2, next_sync_prev;

    always_comb begin
        next_sync_1 = pin;
        next_sync_2 = sync_1;
        next_sync_prev = sync_2;
    end

    // Reset to the idle low level so no false edge follows reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_1 <= next_sync_1;
            sync_2 <= next_sync_2;
            sync_prev <= next_sync_prev;
        end
    end

    // Only the second stage and its delayed copy feed the edge logic
    assign edge_pulse = FALLING ? (~sync_2 & sync_prev) : (sync_2 & ~sync_prev);

endmodule // apv_edge_sync

// *** sim/apv_azimuth_pulse_validator_asserts.sv ***
`timescale 1ns/1ps
module apv_azimuth_pulse_validator_asserts #(
    parameter int CNT_W = 14
) (
    input wire logic clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic azimuth_change_pulse, // Change pin
    input wire logic azimuth_strobe, // Strobe
    input wire logic [CNT_W-1:0] azimuth_count, // Count
    input wire logic s_axi_awvalid, // Aw valid
    input wire logic s_axi_awready, // Aw ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic [1:0] s_axi_bresp, // B resp
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // Ar valid
    input wire logic s_axi_arready, // Ar ready
    input wire logic [31:0] s_axi_rdata, // R data
    input wire logic [1:0] s_axi_rresp, // R resp
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready // R ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_STROBE_PULSE: assert property (azimuth_strobe |=> !azimuth_strobe)
        else $error("strobe longer than one cycle");
    AST_STROBE_ZERO: assert property (azimuth_strobe |-> ##[0:1] azimuth_count == '0)
        else $error("count not zeroed at strobe");
    AST_COUNT_STEP: assert property ($changed(azimuth_count) |->
        azimuth_count == '0 || azimuth_count == $past(azimuth_count) + 1'b1)
        else $error("count moved by other than one");
    AST_COUNT_CAUSE: assert property ($changed(azimuth_count) |->
        $past(azimuth_change_pulse, 3) || $past(azimuth_change_pulse, 4)
        || $past(azimuth_change_pulse, 5) || $past(azimuth_change_pulse, 6))
        else $error("count moved without change pulse");
    AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
        else $error("write taken while busy");
endmodule // apv_azimuth_pulse_validator_asserts

bind apv_azimuth_pulse_validator apv_azimuth_pulse_validator_asserts #(.CNT_W(CNT_W)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .azimuth_change_pulse(azimuth_change_pulse),
    .azimuth_strobe(azimuth_strobe), .azimuth_count(azimuth_count),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** sim/apv_antenna_model.sv ***
`timescale 1ns/1ps
module apv_antenna_model (
    input wire logic clk, // System clock
    output logic azimuth_change_pulse, // Change pulse pin
    output logic azimuth_north_pulse // Reference pulse pin
);
    initial begin
        azimuth_change_pulse = 1'b0;
        azimuth_north_pulse = 1'b0;
    end
    // Wide pulses and gaps so the pin synchroniser sees every edge
    task automatic pulse_change(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            azimuth_change_pulse <= 1'b1;
            repeat (4) @(posedge clk);
            azimuth_change_pulse <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    // Reference event is the falling edge
    task automatic pulse_north();
        @(posedge clk);
        azimuth_north_pulse <= 1'b1;
        repeat (4) @(posedge clk);
        azimuth_north_pulse <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule // apv_antenna_model

// *** sim/apv_azimuth_pulse_validator_tb_top.sv ***
`timescale 1ns/1ps
module apv_azimuth_pulse_validator_tb_top;
    localparam int CW = 4;
    logic clk, sys_rst, chg, north, azimuth_strobe, irq;
    logic [CW-1:0] azimuth_count;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_mismatch = 0;
    int checked = 0;
    int strobes = 0;
    apv_antenna_model u_ant (.clk(clk), .azimuth_change_pulse(chg), .azimuth_north_pulse(north));
    apv_azimuth_pulse_validator #(.CNT_W(CW)) dut (.clk(clk), .sys_rst(sys_rst),
        .azimuth_change_pulse(chg), .azimuth_north_pulse(north), .azimuth_strobe(azimuth_strobe),
        .azimuth_count(azimuth_count), .irq(irq), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (azimuth_strobe === 1'b1) strobes <= strobes + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Ready raised only after valid is seen, so the slave must hold its answer
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, {31'h0, e});
    endtask
    task automatic test_missing();
        u_ant.pulse_change(17);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h1 << apv_pkg::ST_MISSING);
        irq_is(1'b0);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h0);
        wr(apv_pkg::ADDR_IRQ_MASK, 32'h7, r);
        irq_is(1'b1);
        wr(apv_pkg::ADDR_IRQ_STATUS, 32'h1 << apv_pkg::IRQ_MISSING, r);
        irq_is(1'b0);
        $display("test missing_ref done");
    endtask
    task automatic test_good();
        u_ant.pulse_change(16);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h1 << apv_pkg::ST_CARRY);
        u_ant.pulse_north();
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, (32'h1 << apv_pkg::ST_CARRY) | (32'h1 << apv_pkg::ST_REF_SEEN));
        u_ant.pulse_change(1);
        check(strobes, 32'h1);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h0);
        rd(apv_pkg::ADDR_IRQ_STATUS, v, r);
        check(v, 32'h1 << apv_pkg::IRQ_STROBE);
        wr(apv_pkg::ADDR_IRQ_STATUS, 32'h7, r);
        irq_is(1'b0);
        u_ant.pulse_north();
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h1 << apv_pkg::ST_EARLY_PEND);
        $display("test good_rev done");
    endtask
    task automatic test_control();
        wr(apv_pkg::ADDR_CONTROL, 32'h0, r);
        check({30'h0, r}, {30'h0, apv_pkg::RESP_OKAY});
        rd(apv_pkg::ADDR_CONTROL, v, r);
        check(v, 32'h0);
        u_ant.pulse_change(2);
        u_ant.pulse_north();
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h0);
        wr(apv_pkg::ADDR_CONTROL, 32'h1, r);
        u_ant.pulse_change(1);
        check({28'h0, azimuth_count}, 32'h1);
        s_axi_wstrb <= 4'he;
        wr(apv_pkg::ADDR_IRQ_MASK, 32'h0, r);
        s_axi_wstrb <= 4'hf;
        rd(apv_pkg::ADDR_IRQ_MASK, v, r);
        check(v, 32'h7);
        $display("test control done");
    endtask
    task automatic test_reset();
        u_ant.pulse_change(2);
        u_ant.pulse_north();
        check({28'h0, azimuth_count}, 32'h3);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        check({28'h0, azimuth_count}, 32'h0);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h0);
        rd(apv_pkg::ADDR_IRQ_MASK, v, r);
        check(v, {29'h0, apv_pkg::IRQ_MASK_RST});
        rd(apv_pkg::ADDR_CONTROL, v, r);
        check(v, {31'h0, apv_pkg::CTL_ENABLE_RST});
        $display("test reset done");
    endtask
    task automatic test_early();
        u_ant.pulse_change(5);
        u_ant.pulse_north();
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, (32'h1 << apv_pkg::ST_EARLY_PEND) | (32'h5 << 16));
        u_ant.pulse_change(1);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h6 << 16);
        u_ant.pulse_north();
        u_ant.pulse_change(1);
        check({28'h0, azimuth_count}, 32'h0);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h1 << apv_pkg::ST_EARLY);
        rd(apv_pkg::ADDR_STATUS, v, r);
        check(v, 32'h0);
        irq_is(1'b1);
        wr(apv_pkg::ADDR_IRQ_STATUS, 32'h7, r);
        irq_is(1'b0);
        $display("test early_ref done");
    endtask
    task automatic test_unmapped();
        rd(4'h2, v, r);
        check({30'h0, r}, {30'h0, apv_pkg::RESP_SLVERR});
        check(v, 32'h0);
        wr(4'h6, 32'hffffffff, r);
        check({30'h0, r}, {30'h0, apv_pkg::RESP_SLVERR});
        $display("test unmapped done");
    endtask
    initial begin
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        test_missing();
        test_good();
        test_early();
        test_control();
        test_reset();
        test_unmapped();
        wrap_up();
    end
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule // apv_azimuth_pulse_validator_tb_top
